// ### sampler_pkg.sv
// Constants, register map and carrier types for the photometric sample sequencer.
// Assumes a single 10 MHz system clock and a decoded 16-bit register port.
package sampler_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] REG_MODE        = 8'h10;
    localparam logic [7:0] REG_PERIOD      = 8'h12;
    localparam logic [7:0] REG_SLOT_BASE   = 8'h20;
    localparam logic [7:0] REG_SLOT_STRIDE = 8'h08;
    localparam logic [7:0] REG_DATA_BASE   = 8'h40;
    localparam logic [7:0] REG_STATUS      = 8'h44;

    // Slot register field offsets within a slot block
    localparam logic [2:0] F_PULSE_CNT = 3'h0;
    localparam logic [2:0] F_AVG       = 3'h1;
    localparam logic [2:0] F_PULSE_DLY = 3'h2;
    localparam logic [2:0] F_PULSE_WID = 3'h3;
    localparam logic [2:0] F_INT_DLY   = 3'h4;
    localparam logic [2:0] F_INT_WID   = 3'h5;
    localparam int         AVG_FIFO_EN_BIT = 8;

    // ==========================================================
    // Operating modes and reset values
    localparam logic [1:0]  MODE_STANDBY = 2'h0;
    localparam logic [1:0]  MODE_PROGRAM = 2'h1;
    localparam logic [1:0]  MODE_NORMAL  = 2'h2;
    localparam logic [15:0] MODE_RESET   = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'h0020;

    // ==========================================================
    // Timing
    localparam int CLK_HZ         = 10_000_000;
    localparam int CLK_PERIOD_PS  = 100_000;
    localparam int SR_CLK_HZ      = 32_000;
    localparam int SR_DIV_CYC     = CLK_HZ / SR_CLK_HZ;
    localparam int TICK_PS        = 6_250;
    localparam int STEP_PS        = 31_250;
    localparam int US_PS          = 1_000_000;
    localparam int WINDOW_BASE_US = 9;
    localparam int TICKS_PER_CYC  = CLK_PERIOD_PS / TICK_PS;
    localparam int STEP_TICKS     = STEP_PS / TICK_PS;
    localparam int US_TICKS       = US_PS / TICK_PS;

    // ==========================================================
    // Datapath widths
    localparam int NUM_SLOTS = 2;
    localparam int ADC_W     = 14;
    localparam int SAMPLE_W  = 20;
    localparam int ACC_W     = 22;
    localparam int AVG_W     = 27;
    localparam int OUT_W     = 32;
    localparam int T_W       = 18;
    localparam logic [SAMPLE_W-1:0] SAT_MAX = 20'hF_FFFF;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [7:0]  pulse_cnt;
        logic        fifo_en;
        logic [2:0]  avg_log2;
        logic [7:0]  pulse_dly;
        logic [7:0]  pulse_wid;
        logic [10:0] int_dly;
        logic [7:0]  int_wid;
    } slot_cfg_s;

    typedef struct packed {
        logic [OUT_W-1:0] word;
        logic             slot;
    } fifo_word_s;

    typedef enum {ST_IDLE, ST_PULSE, ST_CONV, ST_FINISH} seq_state_e;

endpackage : sampler_pkg

// ### photometric_sample_sequencer.sv
// Mode control, pulse/window timing and sample datapath of the optical front end.
// Assumes ADC results and register strobes come from logic on the same clock.
`timescale 1ns/10ps
module photometric_sample_sequencer
    import sampler_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys_in,
    input  wire logic              rst_in,
    // Register port
    input  wire logic [7:0]        reg_addr_in,
    input  wire logic              reg_wr_in,
    input  wire logic [15:0]       reg_wdata_in,
    input  wire logic              reg_rd_in,
    output logic      [15:0]       reg_rdata_out,
    // Converter
    input  wire logic              adc_valid_in,
    input  wire logic [ADC_W-1:0]  adc_data_in,
    // Front-end timing
    output logic                   led_pulse_out,
    output logic                   window_out,
    // FIFO write side
    output logic                   fifo_valid_out,
    output fifo_word_s             fifo_out
);

    // ==========================================================
    // Registers
    logic [15:0]         mode_q;
    logic [15:0]         period_q;
    slot_cfg_s           cfg_q [NUM_SLOTS];
    logic [T_W-1:0]      pulse_start_t [NUM_SLOTS];
    logic [T_W-1:0]      pulse_end_t [NUM_SLOTS];
    logic [T_W-1:0]      win_start_t [NUM_SLOTS];
    logic [T_W-1:0]      win_end_t [NUM_SLOTS];
    logic [NUM_SLOTS-1:0] cfg_bad;
    logic [NUM_SLOTS-1:0] fifo_ok;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            mode_q   <= MODE_RESET;
            period_q <= PERIOD_RESET;
        end else if (reg_wr_in && reg_addr_in == REG_MODE) begin
            mode_q   <= reg_wdata_in;
        end else if (reg_wr_in && reg_addr_in == REG_PERIOD) begin
            period_q <= reg_wdata_in;
        end
    end

    genvar s;
    generate
        for (s = 0; s < NUM_SLOTS; s++) begin : g_slot
            localparam logic [7:0] BASE = REG_SLOT_BASE + 8'(s * REG_SLOT_STRIDE);
            logic hit;
            assign hit = reg_wr_in && reg_addr_in[7:3] == BASE[7:3];
            always_ff @(posedge clk_sys_in) begin
                if (rst_in) begin
                    cfg_q[s] <= '0;
                    cfg_q[s].pulse_cnt <= 8'h01;
                end else if (hit) begin
                    unique case (reg_addr_in[2:0])
                        F_PULSE_CNT: cfg_q[s].pulse_cnt <= reg_wdata_in[7:0];
                        F_AVG: begin
                            cfg_q[s].avg_log2 <= reg_wdata_in[2:0];
                            cfg_q[s].fifo_en  <= reg_wdata_in[AVG_FIFO_EN_BIT];
                        end
                        F_PULSE_DLY: cfg_q[s].pulse_dly <= reg_wdata_in[7:0];
                        F_PULSE_WID: cfg_q[s].pulse_wid <= reg_wdata_in[7:0];
                        F_INT_DLY:   cfg_q[s].int_dly   <= reg_wdata_in[10:0];
                        F_INT_WID:   cfg_q[s].int_wid   <= reg_wdata_in[7:0];
                        default: ;
                    endcase
                end
            end
            // Timeline in 6.25 ns ticks
            assign pulse_start_t[s] = T_W'(cfg_q[s].pulse_dly * US_TICKS);
            assign pulse_end_t[s]   = T_W'((cfg_q[s].pulse_dly + cfg_q[s].pulse_wid) * US_TICKS);
            assign win_end_t[s]     = T_W'(WINDOW_BASE_US * US_TICKS
                                      + cfg_q[s].int_dly * STEP_TICKS
                                      + cfg_q[s].int_wid * US_TICKS);
            assign win_start_t[s]   = win_end_t[s] - T_W'(cfg_q[s].int_wid * US_TICKS);
            assign cfg_bad[s]       = (win_end_t[s] < pulse_end_t[s])
                                      || (cfg_q[s].int_wid < cfg_q[s].pulse_wid);
        end
    endgenerate

    // Equal factors let both slots feed the FIFO, else slot A only, or slot B alone when slot A's FIFO bit is clear
    assign fifo_ok[0] = cfg_q[0].fifo_en;
    assign fifo_ok[1] = cfg_q[1].fifo_en
                        && (!cfg_q[0].fifo_en || cfg_q[0].avg_log2 == cfg_q[1].avg_log2);

    // ==========================================================
    // Sample-rate clock and period timer
    logic [15:0] sr_div_q;
    logic [15:0] period_cnt_q;
    logic        sr_tick;
    logic        period_tick;

    assign sr_tick     = sr_div_q == 16'(SR_DIV_CYC - 1);
    assign period_tick = sr_tick && period_cnt_q >= period_q;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in || sr_tick) begin
            sr_div_q <= '0;
        end else begin
            sr_div_q <= sr_div_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in || period_tick) begin
            period_cnt_q <= '0;
        end else if (sr_tick) begin
            period_cnt_q <= period_cnt_q + 16'h0001;
        end
    end

    // ==========================================================
    // Pulse sequencer
    seq_state_e          state_q;
    logic                slot_q;
    logic [T_W-1:0]      t_q;
    logic [7:0]          pulse_n_q;
    logic [ACC_W-1:0]    acc_q;
    logic [SAMPLE_W-1:0] sample_sat;
    logic [T_W-1:0]      seq_end_t;
    logic                normal;

    assign normal     = mode_q[1:0] == MODE_NORMAL;
    assign seq_end_t  = (win_end_t[slot_q] > pulse_end_t[slot_q]) ? win_end_t[slot_q] : pulse_end_t[slot_q];
    assign sample_sat = (acc_q > ACC_W'(SAT_MAX)) ? SAT_MAX : acc_q[SAMPLE_W-1:0];

    always_ff @(posedge clk_sys_in) begin
        if (rst_in || !normal) begin
            state_q <= ST_IDLE;
            slot_q  <= 1'b0;
            t_q     <= '0;
            pulse_n_q <= '0;
            acc_q   <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: if (period_tick) begin
                    state_q   <= ST_PULSE;
                    slot_q    <= 1'b0;
                    t_q       <= '0;
                    pulse_n_q <= '0;
                    acc_q     <= '0;
                end
                ST_PULSE: begin
                    t_q <= t_q + T_W'(TICKS_PER_CYC);
                    if (t_q >= seq_end_t) begin
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: if (adc_valid_in) begin
                    acc_q     <= acc_q + ACC_W'(adc_data_in);
                    pulse_n_q <= pulse_n_q + 8'h01;
                    t_q       <= '0;
                    state_q   <= (pulse_n_q + 8'h01 >= cfg_q[slot_q].pulse_cnt) ? ST_FINISH : ST_PULSE;
                end
                ST_FINISH: begin
                    t_q       <= '0;
                    pulse_n_q <= '0;
                    acc_q     <= '0;
                    slot_q    <= 1'b1;
                    state_q   <= slot_q ? ST_IDLE : ST_PULSE;
                end
            endcase
        end
    end

    // Pulse and window gates are driven only in ST_PULSE; conversions are summed later, in ST_CONV
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || !normal || state_q != ST_PULSE) begin
            led_pulse_out <= 1'b0;
            window_out    <= 1'b0;
        end else begin
            led_pulse_out <= t_q >= pulse_start_t[slot_q] && t_q < pulse_end_t[slot_q];
            window_out    <= t_q >= win_start_t[slot_q] && t_q < win_end_t[slot_q];
        end
    end

    // ==========================================================
    // Inter-sample averaging and outputs
    logic [AVG_W-1:0] avg_sum_q [NUM_SLOTS];
    logic [7:0]       avg_cnt_q [NUM_SLOTS];
    logic [OUT_W-1:0] out_q [NUM_SLOTS];
    logic [AVG_W-1:0] new_sum;
    logic             avg_done;

    assign new_sum  = avg_sum_q[slot_q] + AVG_W'(sample_sat);
    assign avg_done = avg_cnt_q[slot_q] == 8'((1 << cfg_q[slot_q].avg_log2) - 1);

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                avg_sum_q[i] <= '0;
                avg_cnt_q[i] <= '0;
                out_q[i]     <= '0;
            end
        end else if (state_q == ST_FINISH && normal) begin
            if (avg_done) begin
                out_q[slot_q]     <= OUT_W'(new_sum);
                avg_sum_q[slot_q] <= '0;
                avg_cnt_q[slot_q] <= '0;
            end else begin
                avg_sum_q[slot_q] <= new_sum;
                avg_cnt_q[slot_q] <= avg_cnt_q[slot_q] + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            fifo_valid_out <= 1'b0;
            fifo_out       <= '0;
        end else begin
            fifo_valid_out <= state_q == ST_FINISH && normal && avg_done && fifo_ok[slot_q];
            fifo_out.word  <= OUT_W'(new_sum >> cfg_q[slot_q].avg_log2);
            fifo_out.slot  <= slot_q;
        end
    end

    // ==========================================================
    // Register read-back
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                REG_MODE:                reg_rdata_out <= mode_q;
                REG_PERIOD:              reg_rdata_out <= period_q;
                REG_DATA_BASE:           reg_rdata_out <= out_q[0][15:0];
                REG_DATA_BASE + 8'h01:   reg_rdata_out <= out_q[0][31:16];
                REG_DATA_BASE + 8'h02:   reg_rdata_out <= out_q[1][15:0];
                REG_DATA_BASE + 8'h03:   reg_rdata_out <= out_q[1][31:16];
                REG_STATUS:              reg_rdata_out <= {12'h000, fifo_ok, cfg_bad};
                default:                 reg_rdata_out <= '0;
            endcase
        end
    end

    // ==========================================================
    // Assertions
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    property p_standby_quiet;
        (mode_q[1:0] != MODE_NORMAL) |=> (state_q == ST_IDLE && !led_pulse_out);
    endproperty
    a_standby_quiet: assert property (p_standby_quiet) else $error("activity outside normal mode");

    property p_program_no_window;
        (mode_q[1:0] == MODE_PROGRAM) |=> !window_out && !fifo_valid_out;
    endproperty
    a_program_no_window: assert property (p_program_no_window) else $error("window in program mode");

    property p_reset_standby;
        $fell(rst_in) |-> (mode_q[1:0] == MODE_STANDBY && state_q == ST_IDLE);
    endproperty
    a_reset_standby: assert property (p_reset_standby) else $error("not standby after reset");

    property p_start_on_period;
        (state_q == ST_IDLE && normal && period_tick) |=> state_q == ST_PULSE;
    endproperty
    a_start_on_period: assert property (p_start_on_period) else $error("period did not start");

    property p_idle_waits;
        (state_q == ST_IDLE && !period_tick) |=> state_q == ST_IDLE;
    endproperty
    a_idle_waits: assert property (p_idle_waits) else $error("start without period tick");

    property p_pulse_count;
        (state_q == ST_CONV && adc_valid_in && normal) |=>
            pulse_n_q == $past(pulse_n_q) + 8'h01;
    endproperty
    a_pulse_count: assert property (p_pulse_count) else $error("pulse count not advanced");

    property p_accumulate;
        (state_q == ST_CONV && adc_valid_in && normal) |=>
            acc_q == $past(acc_q) + ACC_W'($past(adc_data_in));
    endproperty
    a_accumulate: assert property (p_accumulate) else $error("conversion not summed");

    property p_saturate;
        (acc_q > ACC_W'(SAT_MAX)) |-> sample_sat == SAT_MAX;
    endproperty
    a_saturate: assert property (p_saturate) else $error("sample not clipped");

    property p_gated;
        (state_q == ST_PULSE && normal) |=> acc_q == $past(acc_q);
    endproperty
    a_gated: assert property (p_gated) else $error("sum changed outside conversion");

    property p_fifo_divided;
        (state_q == ST_FINISH && normal && avg_done && fifo_ok[slot_q]) |=>
            fifo_valid_out && fifo_out.word == OUT_W'(out_q[fifo_out.slot] >> cfg_q[fifo_out.slot].avg_log2);
    endproperty
    a_fifo_divided: assert property (p_fifo_divided) else $error("fifo word not sum over N");

    c_fifo_word:  cover property (fifo_valid_out);
    c_slot_b:     cover property (state_q == ST_FINISH && slot_q);
    c_averaged:   cover property (state_q == ST_FINISH && avg_done && cfg_q[slot_q].avg_log2 != 3'h0);

endmodule : photometric_sample_sequencer

// ### adc_partner_model.sv
// Behavioural converter facing the front-end window gate output of the sequencer.
// Assumes the bench supplies each next conversion value on next_data_in.
`timescale 1ns/10ps
module adc_partner_model (
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    // Gate and next value
    input  wire logic        window_in,
    input  wire logic [13:0] next_data_in,
    // Converter output
    output logic             adc_valid_out,
    output logic [13:0]      adc_data_out
);
    logic       win_q;
    logic [1:0] wait_q;
    logic       busy_q;

    // ==========================================================
    // Conversion after each window
    always_ff @(posedge clk_sys_in) begin
        win_q         <= window_in;
        adc_valid_out <= 1'b0;
        adc_data_out  <= ~adc_data_out;
        if (rst_in) begin
            busy_q       <= 1'b0;
            wait_q       <= 2'h0;
            adc_data_out <= 14'h2AAA;
        end else if (window_in && !win_q) begin
            adc_valid_out <= 1'b1;
            adc_data_out  <= ~next_data_in;
        end else if (!window_in && win_q) begin
            busy_q <= 1'b1;
            wait_q <= 2'h2;
        end else if (busy_q && wait_q == 2'h0) begin
            busy_q        <= 1'b0;
            adc_valid_out <= 1'b1;
            adc_data_out  <= next_data_in;
        end else if (busy_q) begin
            wait_q <= wait_q - 2'h1;
        end
    end
endmodule : adc_partner_model

// ### photometric_sample_sequencer_tb_top.sv
// Self-checking bench: sum/average model compared at every FIFO word and data read.
// Assumes sampler_pkg, the sequencer and adc_partner_model are compiled first.
`timescale 1ns/10ps
module photometric_sample_sequencer_tb_top;
    import sampler_pkg::*;
    logic             clk_sys_in = 1'b0;
    logic             rst_in = 1'b1;
    logic [7:0]       reg_addr_in = 8'h00;
    logic             reg_wr_in = 1'b0;
    logic             reg_rd_in = 1'b0;
    logic [15:0]      reg_wdata_in = 16'h0000;
    logic [15:0]      reg_rdata_out;
    logic             adc_valid_in;
    logic [ADC_W-1:0] adc_data_in;
    logic [ADC_W-1:0] adc_next = 14'h0123;
    logic             led_pulse_out, window_out, fifo_valid_out, led_q, win_q;
    fifo_word_s       fifo_out;
    logic [31:0]      rnd = 32'h1634;
    logic [32:0]      exp_q[$];
    logic             mon_en = 1'b0;
    int               num_errors = 0, num_checks = 0, nfifo, cs, pidx, rises, cyc, lr, lf, ws, pst, per;
    int               pc[2], kk[2], en[2], dly[2], wid[2], idl[2], iw[2];
    longint           acc, ssum[2], sn[2], last_out[2];

    always #50 clk_sys_in = ~clk_sys_in;

    photometric_sample_sequencer dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .adc_valid_in(adc_valid_in), .adc_data_in(adc_data_in), .led_pulse_out(led_pulse_out),
        .window_out(window_out), .fifo_valid_out(fifo_valid_out), .fifo_out(fifo_out));
    adc_partner_model adc_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .window_in(window_out),
        .next_data_in(adc_next), .adc_valid_out(adc_valid_in), .adc_data_out(adc_data_in));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] v;
        rd(a, v);
        check(33'(v), 33'(e));
    endtask : rchk
    task automatic cfg_slot(input int s, p, k, e, d, w, i, v);
        logic [7:0] b;
        b = REG_SLOT_BASE + 8'(s) * REG_SLOT_STRIDE;
        pc[s] = (p == 0) ? 1 : p;
        kk[s] = k; en[s] = e; dly[s] = d; wid[s] = w; idl[s] = i; iw[s] = v;
        wr(b + 8'(F_PULSE_CNT), 16'(p));
        wr(b + 8'(F_AVG), 16'(k) | (16'(e) << AVG_FIFO_EN_BIT));
        wr(b + 8'(F_PULSE_DLY), 16'(d));
        wr(b + 8'(F_PULSE_WID), 16'(w));
        wr(b + 8'(F_INT_DLY), 16'(i));
        wr(b + 8'(F_INT_WID), 16'(v));
    endtask : cfg_slot
    task automatic do_reset();
        @(posedge clk_sys_in);
        rst_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        cs = 0; pidx = 0; acc = 0; nfifo = 0; rises = 0; pst = 0;
        ssum = '{0, 0}; sn = '{0, 0}; last_out = '{0, 0};
        exp_q.delete();
    endtask : do_reset
    task automatic setup(input int p);
        do_reset();
        rchk(REG_MODE, MODE_RESET);
        wr(REG_MODE, 16'(MODE_PROGRAM));
        per = p;
        wr(REG_PERIOD, 16'(p));
    endtask : setup
    task automatic run(input int n);
        int t;
        mon_en = 1'b1;
        wr(REG_MODE, 16'(MODE_NORMAL));
        rchk(REG_MODE, 16'(MODE_NORMAL));
        for (t = 0; t < 20000 && nfifo < n; t++) @(posedge clk_sys_in);
        check(33'(nfifo), 33'(n));
    endtask : run
    task automatic stop_check();
        logic [15:0] lo, hi;
        mon_en = 1'b0;
        wr(REG_MODE, 16'(MODE_PROGRAM));
        @(posedge clk_sys_in);
        #1 check({led_pulse_out, window_out}, 33'h0);
        for (int s = 0; s < 2; s++) begin
            rd(REG_DATA_BASE + 8'(2 * s), lo);
            rd(REG_DATA_BASE + 8'(2 * s + 1), hi);
            check({1'b0, hi, lo}, 33'(last_out[s]));
        end
    endtask : stop_check
    task automatic results();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results

    // ==========================================================
    // Model and timing monitor
    always @(posedge clk_sys_in) begin
        cyc++;
        if (!rst_in && adc_valid_in && !window_out) begin
            acc += adc_data_in;
            rnd = xs(rnd);
            adc_next <= (adc_next == 14'h3FFF) ? 14'h3FFF : rnd[13:0];
            pidx++;
            if (pidx == pc[cs]) begin
                ssum[cs] += (acc > 'hFFFFF) ? 'hFFFFF : acc;
                sn[cs]++;
                acc = 0;
                pidx = 0;
                if (sn[cs] == (1 << kk[cs])) begin
                    last_out[cs] = ssum[cs];
                    if (en[cs] != 0 && (kk[0] == kk[1] || cs == 0)) exp_q.push_back({32'(ssum[cs] >> kk[cs]), cs[0]});
                    ssum[cs] = 0;
                    sn[cs] = 0;
                end
                cs ^= 1;
            end
        end
        if (fifo_valid_out) begin
            nfifo++;
            check(fifo_out, (exp_q.size() != 0) ? exp_q.pop_front() : '1);
        end
        if (led_pulse_out && !led_q) begin
            rises++;
            if (mon_en && cs == 0 && pidx == 0 && pst != 0) check(33'(cyc - pst), 33'((per + 1) * SR_DIV_CYC));
            if (cs == 0 && pidx == 0) pst = cyc;
            lr = cyc;
        end
        if (mon_en && !led_pulse_out && led_q) begin
            check(33'(cyc - lr), 33'(wid[cs] * 10));
            lf = cyc;
        end
        if (window_out && !win_q) ws = cyc;
        if (mon_en && !window_out && win_q) begin
            check(33'(cyc - ws), 33'(iw[cs] * 10));
            check(33'(cyc - lf), 33'((1440 + 5 * idl[cs] + 160 * iw[cs] - 160 * (dly[cs] + wid[cs])) / 16));
        end
        led_q = led_pulse_out;
        win_q = window_out;
    end

    // ==========================================================
    // Tests
    initial begin
        logic [1:0] modes[4] = '{MODE_STANDBY, MODE_PROGRAM, 2'h3, MODE_PROGRAM};
        setup(3);
        rchk(8'h7F, 16'h0000);
        wr(8'h7F, 16'hFFFF);
        rchk(8'h7F, 16'h0000);
        cfg_slot(0, 2, 2, 1, 10, 2, 0, 3);
        cfg_slot(1, 2, 2, 1, 10, 2, 32, 3);
        rchk(REG_STATUS, 16'h000C);
        foreach (modes[m]) begin
            wr(REG_MODE, 16'(modes[m]));
            rchk(REG_MODE, 16'(modes[m]));
            repeat (1300) @(posedge clk_sys_in);
            check(33'(rises), 33'h0);
        end
        run(2);
        stop_check();
        $display("test 1 done");
        setup(7);
        cfg_slot(0, 2, 1, 1, 10, 2, 0, 3);
        cfg_slot(1, 3, 3, 1, 10, 2, 0, 3);
        rchk(REG_STATUS, 16'h0004);
        run(2);
        stop_check();
        $display("test 2 done");
        setup(30);
        adc_next <= 14'h3FFF;
        cfg_slot(0, 70, 0, 1, 0, 1, 0, 1);
        cfg_slot(1, 0, 0, 0, 0, 1, 0, 1);
        run(1);
        stop_check();
        $display("test 3 done");
        results();
    end

    initial begin
        repeat (80000) @(posedge clk_sys_in);
        num_errors++;
        results();
    end
endmodule : photometric_sample_sequencer_tb_top
